// >>> rtl/dmx_pkg.sv
// package for the data-move instruction group
package dmx_pkg;

    // four-phase instruction cycle
    typedef enum logic [1:0] {
        DMX_Q1 = 2'b00,
        DMX_Q2 = 2'b01,
        DMX_Q3 = 2'b10,
        DMX_Q4 = 2'b11
    } dmx_phase_t;

    // multi-word sequencing
    typedef enum logic [1:0] {
        DMX_ST_FIRST = 2'b00,
        DMX_ST_PTR2 = 2'b01,
        DMX_ST_COPY2 = 2'b10
    } dmx_seq_t;

    // opcode prefixes
    localparam logic [5:0] DMX_OP_REG_MOVE = 6'h14;
    localparam logic [6:0] DMX_OP_ACC_STORE = 7'h37;
    localparam logic [3:0] DMX_OP_COPY_SRC = 4'hC;
    localparam logic [3:0] DMX_OP_COPY_DST = 4'hF;
    localparam logic [7:0] DMX_OP_BANK_LOAD = 8'h01;
    localparam logic [7:0] DMX_OP_LIT_ACC = 8'h0E;
    localparam logic [9:0] DMX_OP_PTR_LOAD = 10'h3B8;
    localparam logic [7:0] DMX_OP_PTR_LOAD2 = 8'hF0;

    // field positions
    localparam int DMX_DIR_BIT = 9;
    localparam int DMX_ACCESS_BIT = 8;
    localparam int DMX_PTR_SEL_LSB = 4;

    // addressing
    localparam logic [7:0] DMX_INDEX_MAX = 8'h5F;
    localparam logic [3:0] DMX_ACCESS_HI_PAGE = 4'hF;
    localparam logic [3:0] DMX_ACCESS_LO_PAGE = 4'h0;
    localparam logic [11:0] DMX_ACC_ADDR = 12'hFE8;
    localparam logic [1:0] DMX_PTR_SEL_MAX = 2'h2;
    localparam logic [1:0] DMX_INDEX_PTR = 2'h2;

    // reset values
    localparam logic [7:0] DMX_ACC_RST = 8'h00;
    localparam logic [7:0] DMX_BANK_RST = 8'h00;
    localparam logic [11:0] DMX_PTR_RST = 12'h000;

    // data memory request
    typedef struct packed {
        logic rd;
        logic wr;
        logic [11:0] addr;
        logic [7:0] wdata;
    } dmx_mem_req_t;

    typedef struct packed {
        dmx_seq_t seq;
        logic act;
        logic have2;
        logic [15:0] ir;
        logic [15:0] w2;
        logic [7:0] tmp;
        logic [7:0] acc;
        logic [7:0] bank;
        logic [2:0][11:0] ptr;
        logic flag_n;
        logic flag_z;
        dmx_mem_req_t mem;
        logic done;
        logic bad_word;
    } dmx_state_t;

    typedef struct packed {
        dmx_phase_t phase;
    } dmx_qstate_t;

endpackage

// >>> rtl/dmx_qphase.sv
// four-phase instruction cycle sequencer
`timescale 1ns/10ps
`default_nettype none
module dmx_qphase (
    input wire logic mclk,
    input wire logic rst_n,
    output dmx_pkg::dmx_phase_t phase
);
    import dmx_pkg::*;

    dmx_qstate_t q;
    dmx_qstate_t d;

    always_comb begin
        d = q;
        case (q.phase)
            DMX_Q1: d.phase = DMX_Q2;
            DMX_Q2: d.phase = DMX_Q3;
            DMX_Q3: d.phase = DMX_Q4;
            DMX_Q4: d.phase = DMX_Q1;
            default: d.phase = DMX_Q1;
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '{phase: DMX_Q1};
        end else begin
            q <= d;
        end
    end

    assign phase = q.phase;

    property p_phase_wrap;
        @(posedge mclk) disable iff (!rst_n)
        (q.phase == DMX_Q1) |-> ##3 (q.phase == DMX_Q4) ##1 (q.phase == DMX_Q1);
    endproperty
    a_phase_wrap: assert property (p_phase_wrap)
        else $error("phase sequence broken");

endmodule
`default_nettype wire

// >>> rtl/dmx_exec.sv
// Function
// - pointer load puts 12-bit literal in pointer 0..2, two words, no flags
// - register move to accumulator (d=0) or back to register; sets sign/zero
// - access bit 0 uses access bank, 1 uses bank selector
// - access 0 with extension on and address at most 95 uses indexed mode
// - 8-bit file field reaches any byte of the selected bank
// - memory copy moves source to destination across 12-bit space, no flags
// - copy is two words, prefixes 1100 source and 1111 destination
// - copy reads in first cycle, writes in second without dummy read
// - copy accepts the accumulator as source or destination
// - bank load takes low nibble, upper bank bits stay zero
// - literal load puts eight-bit literal in accumulator, one cycle, no flags
// - store writes accumulator to file register, one cycle, no flags
`timescale 1ns/10ps
`default_nettype none
module dmx_exec (
    input wire logic mclk,
    input wire logic rst_n,
    input wire logic [15:0] fetch_word,
    input wire logic fetch_valid,
    input wire logic ext_en,
    input wire logic [7:0] dm_rdata,
    output dmx_pkg::dmx_mem_req_t dm_req,
    output dmx_pkg::dmx_phase_t phase,
    output logic [7:0] acc,
    output logic [7:0] bank_sel,
    output logic [11:0] ptr0,
    output logic [11:0] ptr1,
    output logic [11:0] ptr2,
    output logic flag_n,
    output logic flag_z,
    output logic done,
    output logic bad_word
);
    import dmx_pkg::*;

    dmx_state_t q;
    dmx_state_t d;
    logic [11:0] fa;
    logic [7:0] val;
    logic [11:0] dst;

    dmx_qphase u_qphase (
        .mclk(mclk),
        .rst_n(rst_n),
        .phase(phase)
    );

    function automatic logic is_reg_move(input logic [15:0] w);
        return w[15:10] == DMX_OP_REG_MOVE;
    endfunction

    function automatic logic is_store(input logic [15:0] w);
        return w[15:9] == DMX_OP_ACC_STORE;
    endfunction

    function automatic logic is_lit_acc(input logic [15:0] w);
        return w[15:8] == DMX_OP_LIT_ACC;
    endfunction

    function automatic logic is_bank_load(input logic [15:0] w);
        return w[15:8] == DMX_OP_BANK_LOAD;
    endfunction

    // file address from an 8-bit field
    function automatic logic [11:0] file_addr(input logic [15:0] w, input logic [7:0] bk,
                                              input logic [11:0] ip, input logic ext);
        logic [7:0] f;
        f = w[7:0];
        if (w[DMX_ACCESS_BIT]) begin
            return {bk[3:0], f};
        end
        if (ext && f <= DMX_INDEX_MAX) begin
            return ip + {4'h0, f};
        end
        if (f[7]) begin
            return {DMX_ACCESS_HI_PAGE, f};
        end
        return {DMX_ACCESS_LO_PAGE, f};
    endfunction

    assign fa = file_addr(fetch_word, q.bank, q.ptr[DMX_INDEX_PTR], ext_en);
    assign val = (q.mem.addr == DMX_ACC_ADDR) ? q.acc : dm_rdata;
    assign dst = q.w2[11:0];

    always_comb begin
        d = q;
        d.mem.rd = 1'b0;
        d.mem.wr = 1'b0;
        d.done = 1'b0;
        d.bad_word = 1'b0;
        case (phase)
            DMX_Q1: begin
                if (q.seq == DMX_ST_FIRST) begin
                    d.act = fetch_valid;
                    if (fetch_valid) begin
                        d.ir = fetch_word;
                        if (is_reg_move(fetch_word) || is_store(fetch_word)) begin
                            d.mem.addr = fa;
                            d.mem.rd = is_reg_move(fetch_word);
                        end else if (fetch_word[15:12] == DMX_OP_COPY_SRC) begin
                            d.mem.addr = fetch_word[11:0];
                            d.mem.rd = 1'b1;
                        end
                    end
                end else begin
                    // missing second word stretches the op by one more cycle for each Q1 without it
                    d.have2 = fetch_valid;
                    if (fetch_valid) begin
                        d.w2 = fetch_word;
                    end
                end
            end
            DMX_Q2: begin
                if (q.act && (is_reg_move(q.ir) || q.ir[15:12] == DMX_OP_COPY_SRC)) begin
                    d.tmp = val;
                end
            end
            DMX_Q3: begin
                case (q.seq)
                    DMX_ST_FIRST: begin
                        if (q.act) begin
                            d.act = 1'b0;
                            if (is_reg_move(q.ir)) begin
                                d.flag_n = q.tmp[7];
                                d.flag_z = (q.tmp == 8'h00);
                                if (!q.ir[DMX_DIR_BIT] || q.mem.addr == DMX_ACC_ADDR) begin
                                    d.acc = q.tmp;
                                end else begin
                                    d.mem.wr = 1'b1;
                                    d.mem.wdata = q.tmp;
                                end
                                d.done = 1'b1;
                            end else if (is_store(q.ir)) begin
                                if (q.mem.addr != DMX_ACC_ADDR) begin
                                    d.mem.wr = 1'b1;
                                    d.mem.wdata = q.acc;
                                end
                                d.done = 1'b1;
                            end else if (is_lit_acc(q.ir)) begin
                                d.acc = q.ir[7:0];
                                d.done = 1'b1;
                            end else if (is_bank_load(q.ir)) begin
                                d.bank = {4'h0, q.ir[3:0]};
                                d.done = 1'b1;
                            end else if (q.ir[15:12] == DMX_OP_COPY_SRC) begin
                                d.seq = DMX_ST_COPY2;
                            end else if (q.ir[15:6] == DMX_OP_PTR_LOAD) begin
                                if (q.ir[5:4] > DMX_PTR_SEL_MAX) begin
                                    d.bad_word = 1'b1;
                                end else begin
                                    d.ptr[q.ir[5:4]][11:8] = q.ir[3:0];
                                    d.seq = DMX_ST_PTR2;
                                end
                            end
                        end
                    end
                    DMX_ST_PTR2: begin
                        if (q.have2) begin
                            d.seq = DMX_ST_FIRST;
                            if (q.w2[15:8] == DMX_OP_PTR_LOAD2) begin
                                d.ptr[q.ir[5:4]][7:0] = q.w2[7:0];
                                d.done = 1'b1;
                            end else begin
                                d.bad_word = 1'b1;
                            end
                        end
                    end
                    DMX_ST_COPY2: begin
                        if (q.have2) begin
                            d.seq = DMX_ST_FIRST;
                            if (q.w2[15:12] == DMX_OP_COPY_DST) begin
                                // write destination, relies on legal target
                                if (dst == DMX_ACC_ADDR) begin
                                    d.acc = q.tmp;
                                end else begin
                                    d.mem.wr = 1'b1;
                                    d.mem.addr = dst;
                                    d.mem.wdata = q.tmp;
                                end
                                d.done = 1'b1;
                            end else begin
                                d.bad_word = 1'b1;
                            end
                        end
                    end
                    default: d.seq = DMX_ST_FIRST;
                endcase
            end
            default: begin
                d.act = q.act;
            end
        endcase
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= '{seq: DMX_ST_FIRST, act: 1'b0, have2: 1'b0, ir: 16'h0000, w2: 16'h0000,
                   tmp: 8'h00, acc: DMX_ACC_RST, bank: DMX_BANK_RST,
                   ptr: {DMX_PTR_RST, DMX_PTR_RST, DMX_PTR_RST},
                   flag_n: 1'b0, flag_z: 1'b0,
                   mem: '{rd: 1'b0, wr: 1'b0, addr: 12'h000, wdata: 8'h00},
                   done: 1'b0, bad_word: 1'b0};
        end else begin
            q <= d;
        end
    end

    // outputs straight from state flops
    assign dm_req = q.mem;
    assign acc = q.acc;
    assign bank_sel = q.bank;
    assign ptr0 = q.ptr[0];
    assign ptr1 = q.ptr[1];
    assign ptr2 = q.ptr[2];
    assign flag_n = q.flag_n;
    assign flag_z = q.flag_z;
    assign done = q.done;
    assign bad_word = q.bad_word;

    // first-word take at Q1
    sequence s_take(logic hit);
        (phase == DMX_Q1) && (q.seq == DMX_ST_FIRST) && fetch_valid && hit;
    endsequence

    property p_bank_high_zero;
        @(posedge mclk) disable iff (!rst_n)
        bank_sel[7:4] == 4'h0;
    endproperty
    a_bank_high_zero: assert property (p_bank_high_zero)
        else $error("bank selector upper bits set");

    property p_bank_load;
        @(posedge mclk) disable iff (!rst_n)
        s_take(is_bank_load(fetch_word)) |-> ##3 (bank_sel[3:0] == $past(fetch_word[3:0], 3)) && done;
    endproperty
    a_bank_load: assert property (p_bank_load)
        else $error("bank load wrong");

    property p_lit_acc;
        @(posedge mclk) disable iff (!rst_n)
        s_take(is_lit_acc(fetch_word)) |-> ##3 (acc == $past(fetch_word[7:0], 3)) && done
            && $stable(flag_z) && $stable(flag_n);
    endproperty
    a_lit_acc: assert property (p_lit_acc)
        else $error("literal load wrong");

    property p_store;
        @(posedge mclk) disable iff (!rst_n)
        s_take(is_store(fetch_word) && fa != DMX_ACC_ADDR) |-> ##3 dm_req.wr
            && (dm_req.wdata == acc) && done && (dm_req.addr == $past(fa, 3));
    endproperty
    a_store: assert property (p_store)
        else $error("store wrong");

    property p_move_to_acc;
        @(posedge mclk) disable iff (!rst_n)
        s_take(is_reg_move(fetch_word) && !fetch_word[DMX_DIR_BIT] && fa != DMX_ACC_ADDR)
            |=> dm_req.rd ##2 (acc == $past(dm_rdata, 2)) && (flag_z == (acc == 8'h00))
            && (flag_n == acc[7]);
    endproperty
    a_move_to_acc: assert property (p_move_to_acc)
        else $error("register move wrong");

    property p_bank_addr;
        @(posedge mclk) disable iff (!rst_n)
        s_take(is_reg_move(fetch_word) && fetch_word[DMX_ACCESS_BIT])
            |=> dm_req.addr == {$past(bank_sel[3:0]), $past(fetch_word[7:0])};
    endproperty
    a_bank_addr: assert property (p_bank_addr)
        else $error("banked address wrong");

    property p_indexed;
        @(posedge mclk) disable iff (!rst_n)
        s_take((is_reg_move(fetch_word) || is_store(fetch_word))
            && !fetch_word[DMX_ACCESS_BIT] && ext_en
            && fetch_word[7:0] <= DMX_INDEX_MAX)
            |=> dm_req.addr == $past(ptr2) + {4'h0, $past(fetch_word[7:0])};
    endproperty
    a_indexed: assert property (p_indexed)
        else $error("indexed address wrong");

    property p_copy_no_read;
        @(posedge mclk) disable iff (!rst_n)
        (q.seq == DMX_ST_COPY2) |-> !dm_req.rd;
    endproperty
    a_copy_no_read: assert property (p_copy_no_read)
        else $error("dummy read during copy write");

    property p_copy_write;
        @(posedge mclk) disable iff (!rst_n)
        (phase == DMX_Q1) && (q.seq == DMX_ST_COPY2) && fetch_valid
            && fetch_word[15:12] == DMX_OP_COPY_DST && fetch_word[11:0] != DMX_ACC_ADDR
            |-> ##3 dm_req.wr && (dm_req.wdata == q.tmp) && done
            && (dm_req.addr == $past(fetch_word[11:0], 3));
    endproperty
    a_copy_write: assert property (p_copy_write)
        else $error("copy write wrong");

    property p_ptr_flags;
        @(posedge mclk) disable iff (!rst_n)
        (q.seq == DMX_ST_PTR2) |-> $stable(flag_n) && $stable(flag_z);
    endproperty
    a_ptr_flags: assert property (p_ptr_flags)
        else $error("pointer load touched flags");

endmodule
`default_nettype wire

// >>> bench/dmx_data_mem.sv
// banked data memory model facing the data-move block
`timescale 1ns/10ps
`default_nettype none
module dmx_data_mem (
    input wire logic mclk,
    input wire dmx_pkg::dmx_mem_req_t dm_req,
    output logic [7:0] dm_rdata
);
    import dmx_pkg::*;
    logic [7:0] mem [0:4095];
    initial begin
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end
    // full 12-bit space
    // read answers in the strobe cycle; idle shows inverse so stale data never passes
    assign dm_rdata = dm_req.rd ? mem[dm_req.addr] : ~mem[dm_req.addr];
    always @(posedge mclk) begin
        if (dm_req.wr) begin
            mem[dm_req.addr] <= dm_req.wdata;
        end
    end
endmodule
`default_nettype wire

// >>> bench/test_data_move_instruction_exec.sv
// self-checking bench for the data-move instruction group
`timescale 1ns/10ps
`default_nettype none
module test_data_move_instruction_exec;
    import dmx_pkg::*;
    typedef struct packed {
        logic [15:0] w;
        logic [7:0] acc;
        logic [7:0] bank;
        logic n;
        logic z;
        logic mchk;
        logic [11:0] maddr;
        logic [7:0] mdata;
    } dmx_row_t;
    logic mclk = 1'b0;
    logic rst_n, fetch_valid, ext_en, flag_n, flag_z, done, bad_word;
    logic [15:0] fetch_word;
    logic [7:0] dm_rdata, acc, bank_sel;
    logic [11:0] ptr0, ptr1, ptr2;
    dmx_mem_req_t dm_req;
    dmx_phase_t phase;
    int mismatches = 0;
    int checked = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;
    int rd0, wr0;
    dmx_row_t rows [9];
    always #25 mclk = ~mclk;
    always @(posedge mclk) begin
        if (dm_req.rd === 1'b1) rd_cnt++;
        if (dm_req.wr === 1'b1) wr_cnt++;
    end
    dmx_exec u_dut (.mclk(mclk), .rst_n(rst_n), .fetch_word(fetch_word),
        .fetch_valid(fetch_valid), .ext_en(ext_en), .dm_rdata(dm_rdata), .dm_req(dm_req),
        .phase(phase), .acc(acc), .bank_sel(bank_sel), .ptr0(ptr0), .ptr1(ptr1), .ptr2(ptr2),
        .flag_n(flag_n), .flag_z(flag_z), .done(done), .bad_word(bad_word));
    dmx_data_mem u_mem (.mclk(mclk), .dm_req(dm_req), .dm_rdata(dm_rdata));

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [11:0] got, input logic [11:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic mem_chk(input logic [11:0] a, input logic [7:0] d);
        chk({4'h0, u_mem.mem[a]}, {4'h0, d});
    endtask
    // drive one word in Q1, called just after a falling edge
    task automatic issue(input logic [15:0] w);
        int n;
        n = 0;
        while (phase !== DMX_Q1 && n < 8) begin
            @(negedge mclk);
            n++;
        end
        if (n == 8) begin
            mismatches++;
            report_and_stop();
        end
        fetch_word = w;
        fetch_valid = 1'b1;
        @(negedge mclk);
        fetch_valid = 1'b0;
        fetch_word = ~w;
    endtask
    // wait for done or bad_word from Q2, bounded
    task automatic finish_op(input logic exp_bad, input int exp_n);
        int n;
        n = 0;
        while (done !== 1'b1 && bad_word !== 1'b1 && n < 16) begin
            @(negedge mclk);
            n++;
        end
        if (n == 16) begin
            mismatches++;
            report_and_stop();
        end
        chk(12'(n), 12'(exp_n));
        chk(12'(bad_word), 12'(exp_bad));
        chk(12'(done), {11'h000, ~exp_bad});
        @(negedge mclk);
    endtask
    task automatic run2(input logic [15:0] w1, input logic [15:0] w2, input int stall,
                        input logic exp_bad);
        issue(w1);
        repeat (stall) @(negedge mclk);
        issue(w2);
        finish_op(exp_bad, 2);
    endtask
    task automatic store_chk(input logic [15:0] w, input logic [11:0] a);
        issue(w);
        finish_op(1'b0, 2);
        mem_chk(a, 8'h77);
    endtask

    initial begin
        repeat (20000) @(posedge mclk);
        mismatches++;
        report_and_stop();
    end

    initial begin
        rst_n = 1'b0;
        fetch_word = 16'h0000;
        fetch_valid = 1'b0;
        ext_en = 1'b0;
        rows[0] = '{16'h0E5A, 8'h5A, 8'h00, 1'b0, 1'b0, 1'b0, 12'h000, 8'h00};
        rows[1] = '{16'h01F5, 8'h5A, 8'h05, 1'b0, 1'b0, 1'b0, 12'h000, 8'h00};
        rows[2] = '{16'h5110, 8'h80, 8'h05, 1'b1, 1'b0, 1'b0, 12'h000, 8'h00};
        rows[3] = '{16'h5111, 8'h00, 8'h05, 1'b0, 1'b1, 1'b0, 12'h000, 8'h00};
        rows[4] = '{16'h0EC3, 8'hC3, 8'h05, 1'b0, 1'b1, 1'b0, 12'h000, 8'h00};
        rows[5] = '{16'h6E20, 8'hC3, 8'h05, 1'b0, 1'b1, 1'b1, 12'h020, 8'hC3};
        rows[6] = '{16'h6E90, 8'hC3, 8'h05, 1'b0, 1'b1, 1'b1, 12'hF90, 8'hC3};
        rows[7] = '{16'h6FFF, 8'hC3, 8'h05, 1'b0, 1'b1, 1'b1, 12'h5FF, 8'hC3};
        rows[8] = '{16'h5310, 8'hC3, 8'h05, 1'b1, 1'b0, 1'b1, 12'h510, 8'h80};
        repeat (16) @(negedge mclk);
        // preload after the model's own clear at time zero
        u_mem.mem[12'h510] = 8'h80;
        u_mem.mem[12'h511] = 8'h00;
        u_mem.mem[12'h000] = 8'h3C;
        chk({4'h0, acc}, 12'h000);
        chk({4'h0, bank_sel}, 12'h000);
        chk(ptr0 | ptr1 | ptr2, 12'h000);
        chk({8'h00, 2'b00, flag_n, flag_z}, 12'h000);
        chk(12'(phase), 12'(DMX_Q1));
        $display("test reset finished");
        rst_n = 1'b1;
        for (int k = 0; k < 9; k++) begin
            issue(rows[k].w);
            finish_op(1'b0, 2);
            chk({4'h0, acc}, {4'h0, rows[k].acc});
            chk({4'h0, bank_sel}, {4'h0, rows[k].bank});
            chk({10'h000, flag_n, flag_z}, {10'h000, rows[k].n, rows[k].z});
            if (rows[k].mchk) mem_chk(rows[k].maddr, rows[k].mdata);
        end
        $display("test table finished");
        run2(16'hEE23, 16'hF0AB, 0, 1'b0);
        chk(ptr2, 12'h3AB);
        run2(16'hEE0F, 16'hF0FF, 0, 1'b0);
        chk(ptr0, 12'hFFF);
        run2(16'hEE15, 16'hF0A0, 0, 1'b0);
        chk(ptr1, 12'h5A0);
        chk({10'h000, flag_n, flag_z}, 12'h002);
        issue(16'hEE35);
        finish_op(1'b1, 2);
        chk(ptr2, 12'h3AB);
        $display("test pointer load finished");
        // destinations stay clear of program counter and stack top
        rd0 = rd_cnt;
        wr0 = wr_cnt;
        run2(16'hC510, 16'hF700, 0, 1'b0);
        mem_chk(12'h700, 8'h80);
        chk(12'(rd_cnt - rd0), 12'h001);
        chk(12'(wr_cnt - wr0), 12'h001);
        run2(16'hC000, 16'hFFFF, 0, 1'b0);
        mem_chk(12'hFFF, 8'h3C);
        run2(16'hC511, 16'hFFE8, 0, 1'b0);
        chk({4'h0, acc}, 12'h000);
        chk({10'h000, flag_n, flag_z}, 12'h002);
        issue(16'h0E77);
        finish_op(1'b0, 2);
        run2(16'hCFE8, 16'hF0FF, 0, 1'b0);
        mem_chk(12'h0FF, 8'h77);
        run2(16'hC510, 16'hF701, 4, 1'b0);
        mem_chk(12'h701, 8'h80);
        wr0 = wr_cnt;
        run2(16'hC510, 16'hA123, 0, 1'b1);
        chk(12'(wr_cnt - wr0), 12'h000);
        $display("test copy finished");
        ext_en = 1'b1;
        store_chk(16'h6E10, 12'h3BB);
        store_chk(16'h6E5F, 12'h40A);
        store_chk(16'h6E60, 12'h060);
        store_chk(16'h6F30, 12'h530);
        ext_en = 1'b0;
        $display("test indexed finished");
        rst_n = 1'b0;
        repeat (4) @(negedge mclk);
        chk({4'h0, acc}, 12'h000);
        chk({4'h0, bank_sel}, 12'h000);
        chk(ptr2, 12'h000);
        chk({10'h000, flag_n, flag_z}, 12'h000);
        rst_n = 1'b1;
        @(negedge mclk);
        chk(12'(phase), 12'(DMX_Q2));
        chk({11'h000, done}, 12'h000);
        $display("test second reset finished");
        report_and_stop();
    end
endmodule
`default_nettype wire
